// File: rtl/hcd_params.svh
// Constants for the high-current output driver: offsets, fields, reset values, timing.
// Assumes a 100 MHz clock and an Avalon-MM master on the register side.
//
// Contract
// - A sinking channel pulls its load to ground for state 0 and floats it for state 1.
// - A sourcing channel floats its load for state 0 and ties it to the load supply for state 1.
// - A channel newly switched into three-state operation floats until another state is commanded.
// - Three-state operation overrides the sink or source choice, which comes back once it is disabled.
// - A waveform role overrides the static sink or source choice in the same way.
// - An eight-bit enable byte holds one three-state enable per channel, bit n for channel n, 1 enabling.
// - A three-state channel decodes state 0 as ground, 1 as load supply and 2 as high impedance.
// - A three-level state command to a channel without three-state enabled is refused and changes nothing.
// - There are exactly eight channels, 0 to 7, and any other index is refused.
// - Duty runs from 0 to 100 percent and any larger request is limited to 100 percent.
// - A mode code picks one of six idle and pulsed drive pairs for a waveform channel.
// - Each phase of a waveform may take any of the three drive states, per channel.
// - A channel's duty edge may be bound to the leading or trailing edge of another waveform channel.
// - Duty -1 with a binding takes the duty edge from the bound channel instead of a programmed duty.
// - A mode conflict is reported as a bitmap with a 1 for each pin not set up for the request.
`ifndef HCD_PARAMS_SVH
`define HCD_PARAMS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define HCD_NCH 8
`define HCD_CH_W 3
`define HCD_ADDR_W 5
`define HCD_PER_W 20
`define HCD_DUTY_W 11

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HCD_OFF_SS_SEL 5'h00
`define HCD_OFF_TRI_EN 5'h04
`define HCD_OFF_STATIC 5'h08
`define HCD_OFF_STATUS 5'h0C
`define HCD_OFF_PERIOD 5'h10
`define HCD_OFF_WAVE 5'h14
`define HCD_OFF_DRIVE 5'h18
`define HCD_OFF_WAVE_EN 5'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HCD_F_CH_HI 3
`define HCD_F_CH_LO 0
`define HCD_F_CH_BAD 3
`define HCD_SC_ST_HI 9
`define HCD_SC_ST_LO 8
`define HCD_SC_TRI 16
`define HCD_WV_MODE_HI 6
`define HCD_WV_MODE_LO 4
`define HCD_WV_EN 7
`define HCD_WV_BIND_HI 9
`define HCD_WV_BIND_LO 8
`define HCD_WV_SRC_HI 12
`define HCD_WV_SRC_LO 10
`define HCD_WV_DUTY_HI 26
`define HCD_WV_DUTY_LO 16
`define HCD_ST_ERR 0
`define HCD_ST_MAP_HI 15
`define HCD_ST_MAP_LO 8

// ----------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------
`define HCD_PERIOD_KEEP 32'hFFFF_FFFF
`define HCD_PERIOD_RST 20'h0_03E8
`define HCD_DUTY_FULL 11'h3E8
`define HCD_DUTY_BOUND 11'h7FF
`define HCD_MODE_LAST 3'h5
`define HCD_ST_HIZ_CMD 2'h2
`define HCD_BYTE_RST 8'h00

// ----------------------------------------------------------------
// Timing: one waveform tick per microsecond
// ----------------------------------------------------------------
`define HCD_CLK_MHZ 100
`define HCD_TICK_US 1
`define HCD_TICK_CYCLES (`HCD_CLK_MHZ * `HCD_TICK_US)
`define HCD_PRE_W 7

`endif

// File: rtl/hcd_pkg.sv
// Types shared by the high-current output driver modules.
// Assumes hcd_params.svh for all numeric constants.
`default_nettype none

package hcd_pkg;

	// ----------------------------------------------------------------
	// Drive states of one output
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		hcd_drv_gnd = 2'h0,
		hcd_drv_supply = 2'h1,
		hcd_drv_hiz = 2'h2
	} hcd_drive_t;

	// ----------------------------------------------------------------
	// Idle and pulsed pairs of a waveform channel
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		idle_hiz_pulse_sink = 3'h0,
		idle_hiz_pulse_source = 3'h1,
		idle_sink_pulse_source = 3'h2,
		idle_source_pulse_sink = 3'h3,
		idle_sink_pulse_hiz = 3'h4,
		idle_source_pulse_hiz = 3'h5
	} hcd_mode_t;

	// ----------------------------------------------------------------
	// Edge binding selections
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		hcd_bind_none = 2'h0,
		bind_to_leading_edge = 2'h1,
		bind_to_trailing_edge = 2'h2
	} hcd_bind_t;

endpackage

`default_nettype wire

// File: rtl/hcd_chan.sv
// One waveform channel: duty threshold and drive of each phase.
// Assumes the shared period counter and the bound threshold come from the top.
`default_nettype none
`include "hcd_params.svh"

module hcd_chan (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Shared timebase
	input wire logic [`HCD_PER_W-1:0] cnt,
	input wire logic [`HCD_PER_W-1:0] period,
	// Channel setup
	input wire logic [`HCD_DUTY_W-1:0] duty,
	input wire hcd_pkg::hcd_mode_t mode,
	input wire logic use_bound,
	input wire logic [`HCD_PER_W-1:0] bound_thr,
	// Results
	output logic [`HCD_PER_W-1:0] thr,
	output hcd_pkg::hcd_drive_t drive
);

	logic [`HCD_PER_W+`HCD_DUTY_W-1:0] prod;
	logic [`HCD_PER_W+`HCD_DUTY_W-1:0] quot;
	logic [`HCD_PER_W-1:0] eff_thr;

	// ----------------------------------------------------------------
	// Drive of a phase for a mode
	// ----------------------------------------------------------------
	function automatic hcd_pkg::hcd_drive_t phase_drive(input hcd_pkg::hcd_mode_t m, input logic pulsed);
		hcd_pkg::hcd_drive_t d;
		d = hcd_pkg::hcd_drv_hiz;
		case (m)
			hcd_pkg::idle_hiz_pulse_sink: d = pulsed ? hcd_pkg::hcd_drv_gnd : hcd_pkg::hcd_drv_hiz;
			hcd_pkg::idle_hiz_pulse_source: d = pulsed ? hcd_pkg::hcd_drv_supply : hcd_pkg::hcd_drv_hiz;
			hcd_pkg::idle_sink_pulse_source: d = pulsed ? hcd_pkg::hcd_drv_supply : hcd_pkg::hcd_drv_gnd;
			hcd_pkg::idle_source_pulse_sink: d = pulsed ? hcd_pkg::hcd_drv_gnd : hcd_pkg::hcd_drv_supply;
			hcd_pkg::idle_sink_pulse_hiz: d = pulsed ? hcd_pkg::hcd_drv_hiz : hcd_pkg::hcd_drv_gnd;
			hcd_pkg::idle_source_pulse_hiz: d = pulsed ? hcd_pkg::hcd_drv_hiz : hcd_pkg::hcd_drv_supply;
			default: d = hcd_pkg::hcd_drv_hiz;
		endcase
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Threshold follows period changes, so duty percent is kept
	// ----------------------------------------------------------------
	assign prod = (`HCD_PER_W+`HCD_DUTY_W)'(period) * (`HCD_PER_W+`HCD_DUTY_W)'(duty);
	assign quot = prod / (`HCD_PER_W+`HCD_DUTY_W)'(`HCD_DUTY_FULL);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			thr <= '0;
		end else begin
			thr <= quot[`HCD_PER_W-1:0];
		end
	end

	assign eff_thr = use_bound ? bound_thr : thr;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drive <= hcd_pkg::hcd_drv_hiz;
		end else begin
			drive <= phase_drive(mode, cnt < eff_thr);
		end
	end

endmodule

`default_nettype wire

// File: rtl/hcd_top.sv
// Top of the high-current output driver: Avalon-MM registers, static and waveform drive.
// Assumes one 100 MHz clock and external high-side and low-side switches on each pin.
`default_nettype none
`include "hcd_params.svh"

module hcd_top (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [`HCD_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Output switches
	output logic [`HCD_NCH-1:0] hc_output_channels_sink_en,
	output logic [`HCD_NCH-1:0] hc_output_channels_source_en
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic wait_r;
	logic [31:0] rdata_r;
	logic acc;
	logic wr;
	logic wr_full;
	logic [`HCD_NCH-1:0] ss_sel_r;
	logic [`HCD_NCH-1:0] tri_en_r;
	logic [`HCD_NCH-1:0] wave_en_r;
	logic [`HCD_NCH-1:0] duty_bound_r;
	hcd_pkg::hcd_drive_t ss_drive_r [`HCD_NCH];
	hcd_pkg::hcd_drive_t tri_drive_r [`HCD_NCH];
	hcd_pkg::hcd_mode_t mode_r [`HCD_NCH];
	hcd_pkg::hcd_bind_t bind_r [`HCD_NCH];
	logic [`HCD_CH_W-1:0] src_r [`HCD_NCH];
	logic [`HCD_DUTY_W-1:0] duty_r [`HCD_NCH];
	logic [`HCD_PER_W-1:0] period_r;
	logic [`HCD_PER_W-1:0] cnt_r;
	logic [`HCD_PRE_W-1:0] pre_r;
	logic tick;
	logic err_r;
	logic [`HCD_NCH-1:0] map_r;
	logic [`HCD_PER_W-1:0] thr [`HCD_NCH];
	logic [`HCD_PER_W-1:0] bthr [`HCD_NCH];
	hcd_pkg::hcd_drive_t wave_drive [`HCD_NCH];
	hcd_pkg::hcd_drive_t final_drive [`HCD_NCH];
	logic [2*`HCD_NCH-1:0] drive_bus;

	// Static command fields
	logic [`HCD_F_CH_HI:`HCD_F_CH_LO] sc_ch;
	logic [`HCD_CH_W-1:0] sc_idx;
	logic [1:0] sc_st;
	logic sc_tri;
	logic sc_ok;
	logic sc_go;

	// Waveform command fields
	logic [`HCD_F_CH_HI:`HCD_F_CH_LO] wv_ch;
	logic [`HCD_CH_W-1:0] wv_idx;
	logic [2:0] wv_mode;
	logic wv_en;
	logic [1:0] wv_bind;
	logic [`HCD_CH_W-1:0] wv_src;
	logic [`HCD_DUTY_W-1:0] wv_duty;
	logic [`HCD_DUTY_W-1:0] wv_duty_lim;
	logic wv_is_bound;
	logic wv_bad;
	logic wv_conflict;
	logic wv_go;
	logic [`HCD_NCH-1:0] wv_map;
	logic per_bad;
	logic [`HCD_NCH-1:0] tri_new;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic at(input logic [`HCD_ADDR_W-1:0] a, input logic [`HCD_ADDR_W-1:0] off);
		return a == off;
	endfunction

	// Channel index field is four bits wide so that 8 to 15 can be seen and refused
	function automatic logic ch_bad(input logic [`HCD_F_CH_HI:`HCD_F_CH_LO] c);
		return c[`HCD_F_CH_BAD];
	endfunction

	// Two-level state mapped through the sink or source choice
	function automatic hcd_pkg::hcd_drive_t two_level(input logic sourcing, input logic st);
		hcd_pkg::hcd_drive_t d;
		d = hcd_pkg::hcd_drv_hiz;
		if (sourcing) begin
			d = st ? hcd_pkg::hcd_drv_supply : hcd_pkg::hcd_drv_hiz;
		end else begin
			d = st ? hcd_pkg::hcd_drv_hiz : hcd_pkg::hcd_drv_gnd;
		end
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Avalon handshake: one wait cycle, then answer with data
	// ----------------------------------------------------------------
	assign acc = (avs_read || avs_write) && !wait_r;
	assign wr = acc && avs_write;
	assign wr_full = wr && (&avs_byteenable);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 1'b1;
		end else if ((avs_read || avs_write) && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read && wait_r) begin
			rdata_r <= 32'h0000_0000;
			case (avs_address)
				`HCD_OFF_SS_SEL: rdata_r[`HCD_NCH-1:0] <= ss_sel_r;
				`HCD_OFF_TRI_EN: rdata_r[`HCD_NCH-1:0] <= tri_en_r;
				`HCD_OFF_STATUS: begin
					rdata_r[`HCD_ST_ERR] <= err_r;
					rdata_r[`HCD_ST_MAP_HI:`HCD_ST_MAP_LO] <= map_r;
				end
				`HCD_OFF_PERIOD: rdata_r[`HCD_PER_W-1:0] <= period_r;
				`HCD_OFF_DRIVE: rdata_r[2*`HCD_NCH-1:0] <= drive_bus;
				`HCD_OFF_WAVE_EN: rdata_r[`HCD_NCH-1:0] <= wave_en_r;
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;

	// ----------------------------------------------------------------
	// Command field extraction and checks
	// ----------------------------------------------------------------
	assign sc_ch = avs_writedata[`HCD_F_CH_HI:`HCD_F_CH_LO];
	assign sc_idx = sc_ch[`HCD_CH_W-1:0];
	assign sc_st = avs_writedata[`HCD_SC_ST_HI:`HCD_SC_ST_LO];
	assign sc_tri = avs_writedata[`HCD_SC_TRI];
	assign sc_go = wr_full && at(avs_address, `HCD_OFF_STATIC);
	// Two-level commands take 0 or 1, three-level ones 0, 1 or 2
	assign sc_ok = !ch_bad(sc_ch) && (sc_tri ? (tri_en_r[sc_idx] && (sc_st <= `HCD_ST_HIZ_CMD))
		: (!tri_en_r[sc_idx] && !sc_st[1]));

	assign wv_ch = avs_writedata[`HCD_F_CH_HI:`HCD_F_CH_LO];
	assign wv_idx = wv_ch[`HCD_CH_W-1:0];
	assign wv_mode = avs_writedata[`HCD_WV_MODE_HI:`HCD_WV_MODE_LO];
	assign wv_en = avs_writedata[`HCD_WV_EN];
	assign wv_bind = avs_writedata[`HCD_WV_BIND_HI:`HCD_WV_BIND_LO];
	assign wv_src = avs_writedata[`HCD_WV_SRC_HI:`HCD_WV_SRC_LO];
	assign wv_duty = avs_writedata[`HCD_WV_DUTY_HI:`HCD_WV_DUTY_LO];
	assign wv_go = wr_full && at(avs_address, `HCD_OFF_WAVE);
	assign wv_is_bound = (wv_duty == `HCD_DUTY_BOUND);
	assign wv_duty_lim = (wv_duty > `HCD_DUTY_FULL) ? `HCD_DUTY_FULL : wv_duty;
	assign wv_bad = ch_bad(wv_ch) || (wv_en && ((wv_mode > `HCD_MODE_LAST)
		|| (wv_bind == 2'h3) || (wv_is_bound && (wv_bind == 2'h0))));

	// A bound edge must come from another running, unbound waveform channel
	assign wv_conflict = wv_en && wv_is_bound && (wv_bind != 2'h0)
		&& (!wave_en_r[wv_src] || duty_bound_r[wv_src] || (wv_src == wv_idx));
	assign wv_map = wv_conflict ? (`HCD_NCH'(1) << wv_src) : '0;

	assign per_bad = (avs_writedata != `HCD_PERIOD_KEEP) && (avs_writedata[`HCD_PER_W-1:0] == '0);

	// ----------------------------------------------------------------
	// Status: refused commands and mode conflicts, write 1 to clear
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_r <= 1'b0;
		end else if ((sc_go && !sc_ok) || (wv_go && (wv_bad || wv_conflict))
			|| (wr_full && at(avs_address, `HCD_OFF_PERIOD) && per_bad)) begin
			err_r <= 1'b1;
		end else if (wr && avs_byteenable[0] && at(avs_address, `HCD_OFF_STATUS) && avs_writedata[`HCD_ST_ERR]) begin
			err_r <= 1'b0;
		end
	end

	// New conflict bits win over a clear in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			map_r <= `HCD_BYTE_RST;
		end else if (wr && avs_byteenable[1] && at(avs_address, `HCD_OFF_STATUS)) begin
			map_r <= (map_r & ~avs_writedata[`HCD_ST_MAP_HI:`HCD_ST_MAP_LO]) | (wv_go && !wv_bad ? wv_map : '0);
		end else if (wv_go && !wv_bad) begin
			map_r <= map_r | wv_map;
		end
	end

	// ----------------------------------------------------------------
	// Configuration bytes
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ss_sel_r <= `HCD_BYTE_RST;
		end else if (wr && avs_byteenable[0] && at(avs_address, `HCD_OFF_SS_SEL)) begin
			ss_sel_r <= avs_writedata[`HCD_NCH-1:0];
		end
	end

	assign tri_new = avs_writedata[`HCD_NCH-1:0] & ~tri_en_r;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tri_en_r <= `HCD_BYTE_RST;
		end else if (wr && avs_byteenable[0] && at(avs_address, `HCD_OFF_TRI_EN)) begin
			tri_en_r <= avs_writedata[`HCD_NCH-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Shared timebase: microsecond tick and one period counter
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pre_r <= '0;
		end else if (pre_r == `HCD_PRE_W'(`HCD_TICK_CYCLES - 1)) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + `HCD_PRE_W'(1);
		end
	end

	assign tick = (pre_r == `HCD_PRE_W'(`HCD_TICK_CYCLES - 1));

	// The all-ones value keeps the block's current period
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			period_r <= `HCD_PERIOD_RST;
		end else if (wr_full && at(avs_address, `HCD_OFF_PERIOD) && !per_bad
			&& (avs_writedata != `HCD_PERIOD_KEEP)) begin
			period_r <= avs_writedata[`HCD_PER_W-1:0];
		end
	end

	// Greater-or-equal wrap avoids a long run-out when the period shrinks
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (tick) begin
			if (cnt_r >= period_r - `HCD_PER_W'(1)) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + `HCD_PER_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-channel state
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `HCD_NCH; g++) begin : ch
			// Static sink/source drive, floated on each new configuration
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					ss_drive_r[g] <= hcd_pkg::hcd_drv_hiz;
				end else if (wr && avs_byteenable[0] && at(avs_address, `HCD_OFF_SS_SEL)) begin
					ss_drive_r[g] <= hcd_pkg::hcd_drv_hiz;
				end else if (sc_go && sc_ok && !sc_tri && (sc_idx == `HCD_CH_W'(g))) begin
					ss_drive_r[g] <= two_level(ss_sel_r[g], sc_st[0]);
				end
			end

			// Three-level drive, floated when the channel first enters three-state use
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					tri_drive_r[g] <= hcd_pkg::hcd_drv_hiz;
				end else if (wr && avs_byteenable[0] && at(avs_address, `HCD_OFF_TRI_EN) && tri_new[g]) begin
					tri_drive_r[g] <= hcd_pkg::hcd_drv_hiz;
				end else if (sc_go && sc_ok && sc_tri && (sc_idx == `HCD_CH_W'(g))) begin
					tri_drive_r[g] <= hcd_pkg::hcd_drive_t'(sc_st);
				end
			end

			// Waveform setup; a refused command changes nothing
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					wave_en_r[g] <= 1'b0;
					duty_bound_r[g] <= 1'b0;
					mode_r[g] <= hcd_pkg::idle_hiz_pulse_sink;
					bind_r[g] <= hcd_pkg::hcd_bind_none;
					src_r[g] <= '0;
					duty_r[g] <= '0;
				end else if (wv_go && !wv_bad && !wv_conflict && (wv_idx == `HCD_CH_W'(g))) begin
					wave_en_r[g] <= wv_en;
					duty_bound_r[g] <= wv_en && wv_is_bound;
					mode_r[g] <= hcd_pkg::hcd_mode_t'(wv_mode);
					bind_r[g] <= hcd_pkg::hcd_bind_t'(wv_bind);
					src_r[g] <= wv_src;
					duty_r[g] <= wv_is_bound ? '0 : wv_duty_lim;
				end
			end

			// Leading edges of all channels sit at count zero of the shared period
			assign bthr[g] = (bind_r[g] == hcd_pkg::bind_to_trailing_edge) ? thr[src_r[g]] : '0;

			hcd_chan u_chan (
				.clock(clock),
				.rst_n(rst_n),
				.cnt(cnt_r),
				.period(period_r),
				.duty(duty_r[g]),
				.mode(mode_r[g]),
				.use_bound(duty_bound_r[g]),
				.bound_thr(bthr[g]),
				.thr(thr[g]),
				.drive(wave_drive[g])
			);

			// Waveform beats three-state, which beats sink/source
			assign final_drive[g] = wave_en_r[g] ? wave_drive[g]
				: (tri_en_r[g] ? tri_drive_r[g] : ss_drive_r[g]);
			assign drive_bus[2*g+1:2*g] = final_drive[g];

			// Switch enables are registered so both never glitch on together
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					hc_output_channels_sink_en[g] <= 1'b0;
					hc_output_channels_source_en[g] <= 1'b0;
				end else begin
					hc_output_channels_sink_en[g] <= (final_drive[g] == hcd_pkg::hcd_drv_gnd);
					hc_output_channels_source_en[g] <= (final_drive[g] == hcd_pkg::hcd_drv_supply);
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// File: tb/hcd_assertions.sv
// Checker for hcd_top: bus handshake timing and pin drive relations.
// Assumes it is bound to hcd_top and sees only its ports.
`default_nettype none
`include "hcd_params.svh"

module hcd_assertions (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [`HCD_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Output switches
	input wire logic [`HCD_NCH-1:0] hc_output_channels_sink_en,
	input wire logic [`HCD_NCH-1:0] hc_output_channels_source_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc, tri_wr, wave_r;
	logic [7:0] tri_r, rise_r;
	logic [15:0] pins;
	assign acc = avs_write && !avs_waitrequest;
	assign tri_wr = acc && avs_address == `HCD_OFF_TRI_EN && avs_byteenable[0];
	assign pins = {hc_output_channels_sink_en, hc_output_channels_source_en};
	// Waveforms move pins on their own, so static checks stop once one is written
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			wave_r <= 1'b0;
		else if (acc && avs_address == `HCD_OFF_WAVE)
			wave_r <= 1'b1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tri_r <= 8'h00;
			rise_r <= 8'h00;
		end else if (tri_wr) begin
			tri_r <= avs_writedata[7:0];
			rise_r <= avs_writedata[7:0] & ~tri_r;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence req_new;
		$rose(avs_read || avs_write);
	endsequence
	sequence one_wait;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_wait_answer: assert property (req_new |=> one_wait)
		else $error("answer not after one wait");
	a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
		else $error("answer without request");
	a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("answer while idle");
	a_data_cause: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
		else $error("read data moved outside a read");
	a_no_overlap: assert property ((hc_output_channels_sink_en & hc_output_channels_source_en) == 8'h00)
		else $error("both switches on");
	a_reset_float: assert property (!$past(rst_n) |-> pins == 16'h0000)
		else $error("pins driven after reset");
	a_pin_cause: assert property (!wave_r && $changed(pins) |-> $past(acc, 2))
		else $error("pins moved without a command");
	a_tri_float: assert property (tri_wr && !wave_r |=> ##1 ((pins[15:8] | pins[7:0]) & rise_r) == '0)
		else $error("new three-state channel driven");
endmodule

bind hcd_top hcd_assertions i_hcd_assertions (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.hc_output_channels_sink_en(hc_output_channels_sink_en),
	.hc_output_channels_source_en(hc_output_channels_source_en));
`default_nettype wire

// File: tb/hcd_load.sv
// Load model for the eight high-current pins.
// Assumes the switch enables of hcd_top; a floating pin flips every cycle.
`default_nettype none

module hcd_load (
	// Clock
	input wire logic clock,
	// Switches
	input wire logic [7:0] sink_en,
	input wire logic [7:0] source_en,
	// Pin view
	output logic [7:0] floating,
	output logic [7:0] level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_r = 8'h00;
	// Both switches off leaves the pin floating
	assign floating = ~(sink_en | source_en);
	// No level is defined when floating, so it toggles rather than holding
	assign level = source_en | (floating & ~last_r);
	always_ff @(posedge clock)
		last_r <= level;
endmodule
`default_nettype wire

// File: tb/high_current_output_driver_test.sv
// Bench for hcd_top: bus tasks, a drive model, read results checked off a queue.
// Assumes hcd_top, its checker and hcd_load are compiled first.
`default_nettype none
`include "hcd_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end

module high_current_output_driver_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic avs_waitrequest;
	logic [3:0] avs_byteenable = 4'hf;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, r, e;
	logic [7:0] sink, src, flt, lvl, ss, hz, tri_en, wv;
	logic [1:0] sd [8], td [8], wd [8];
	logic [31:0] q [$];
	int failures = 0;
	int num_checks = 0;
	hcd_top i_hcd_top (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.hc_output_channels_sink_en(sink), .hc_output_channels_source_en(src));
	hcd_load i_hcd_load (.clock(clock), .sink_en(sink), .source_en(src), .floating(flt), .level(lvl));
	initial forever #5 clock = ~clock;
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Holds the request until waitrequest is seen low, then idles one edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			summarize();
		end
		@(posedge clock);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] x);
		q.push_back(x);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	function automatic logic [31:0] drv();
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int c = 0; c < 8; c++)
			v[2*c +: 2] = wv[c] ? wd[c] : tri_en[c] ? td[c] : sd[c];
		return v;
	endfunction
	always @(posedge clock) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			e = q.pop_front();
			`CHK(avs_readdata, e)
		end
	end
	initial begin
		r = $urandom(32'h1bf3);
		sd = '{default: 2'h2};
		td = '{default: 2'h2};
		wd = '{default: 2'h2};
		tri_en = 8'h00;
		wv = 8'h00;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(`HCD_OFF_DRIVE, 32'h0000_aaaa);
		rd(`HCD_OFF_PERIOD, 32'h0000_03e8);
		ss = 8'($urandom);
		bus(1'b1, `HCD_OFF_SS_SEL, 32'(ss));
		for (int c = 0; c < 8; c++) begin
			r = $urandom & 32'h0000_0001;
			bus(1'b1, `HCD_OFF_STATIC, 32'(c) | r << 8);
			sd[c] = ss[c] ? (r[0] ? 2'h1 : 2'h2) : (r[0] ? 2'h2 : 2'h0);
			hz[c] = sd[c] == 2'h2;
		end
		rd(`HCD_OFF_DRIVE, drv());
		`CHK(flt, hz)
		`CHK(lvl & ~flt, ss & ~hz)
		avs_byteenable <= 4'h1;
		bus(1'b1, `HCD_OFF_STATIC, 32'h0000_0100);
		avs_byteenable <= 4'hf;
		bus(1'b1, `HCD_OFF_STATIC, 32'h0000_0008);
		bus(1'b1, `HCD_OFF_DRIVE, 32'h0000_0000);
		rd(`HCD_OFF_DRIVE, drv());
		rd(`HCD_OFF_STATUS, 32'h0000_0001);
		rd(5'h1e, 32'h0000_0000);
		tri_en = 8'($urandom);
		bus(1'b1, `HCD_OFF_TRI_EN, 32'(tri_en));
		rd(`HCD_OFF_TRI_EN, 32'(tri_en));
		rd(`HCD_OFF_DRIVE, drv());
		for (int c = 0; c < 8; c++) begin
			r = $urandom % 3;
			bus(1'b1, `HCD_OFF_STATIC, 32'h0001_0000 | 32'(c) | r << 8);
			td[c] = tri_en[c] ? r[1:0] : td[c];
		end
		bus(1'b1, `HCD_OFF_STATIC, 32'h0001_0300);
		rd(`HCD_OFF_DRIVE, drv());
		tri_en = 8'h00;
		bus(1'b1, `HCD_OFF_TRI_EN, 32'h0000_0000);
		rd(`HCD_OFF_DRIVE, drv());
		bus(1'b1, `HCD_OFF_STATUS, 32'h0000_ff01);
		bus(1'b1, `HCD_OFF_PERIOD, 32'h0000_0014);
		wv = 8'h01;
		// Threshold is registered before the drive, so a new duty shows one edge later
		for (int m = 0; m < 6; m++) begin
			bus(1'b1, `HCD_OFF_WAVE, 32'h03e8_0080 | 32'(m) << 4);
			wd[0] = 2'(12'ha14 >> 2 * m);
			@(posedge clock);
			rd(`HCD_OFF_DRIVE, drv());
			bus(1'b1, `HCD_OFF_WAVE, 32'h0000_0080 | 32'(m) << 4);
			wd[0] = 2'(12'h44a >> 2 * m);
			@(posedge clock);
			rd(`HCD_OFF_DRIVE, drv());
		end
		bus(1'b1, `HCD_OFF_WAVE, 32'h07f0_00a0);
		wd[0] = 2'h1;
		@(posedge clock);
		rd(`HCD_OFF_DRIVE, drv());
		bus(1'b1, `HCD_OFF_WAVE, 32'h07ff_02b1);
		bus(1'b1, `HCD_OFF_WAVE, 32'h07ff_01b2);
		wv = 8'h07;
		wd[1] = 2'h0;
		wd[2] = 2'h1;
		rd(`HCD_OFF_DRIVE, drv());
		rd(`HCD_OFF_WAVE_EN, 32'h0000_0007);
		bus(1'b1, `HCD_OFF_WAVE, 32'h07ff_16b3);
		rd(`HCD_OFF_STATUS, 32'h0000_2001);
		rd(`HCD_OFF_DRIVE, drv());
		bus(1'b1, `HCD_OFF_PERIOD, 32'hffff_ffff);
		rd(`HCD_OFF_PERIOD, 32'h0000_0014);
		for (int c = 2; c >= 0; c--)
			bus(1'b1, `HCD_OFF_WAVE, 32'(c));
		wv = 8'h00;
		rd(`HCD_OFF_DRIVE, drv());
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(`HCD_OFF_DRIVE, 32'h0000_aaaa);
		summarize();
	end
endmodule
`default_nettype wire
